// >>> rtl/tat_consts.svh
`ifndef TAT_CONSTS_SVH
`define TAT_CONSTS_SVH
// register byte offsets
`define TAT_OFF_TEMP  8'h00
`define TAT_OFF_CFG   8'h04
`define TAT_OFF_LOW   8'h08
`define TAT_OFF_HIGH  8'h0C
`define TAT_OFF_STAT  8'h10
// configuration bit positions
`define TAT_CFG_PD    0
`define TAT_CFG_MODE  1
`define TAT_CFG_INV   2
`define TAT_CFG_FQLO  3
`define TAT_CFG_FQHI  4
`define TAT_CFG_TR    7
// reset values
`define TAT_CFG_RST   8'h00
`define TAT_TEMP_RST  16'h0000
`define TAT_LOW_RST   16'h4B00
`define TAT_HIGH_RST  16'h5000
// sample keeps 12 significant bits, low nibble zero
`define TAT_TEMP_MASK 16'hFFF0
// fault queue lengths per setting
`define TAT_FQ_0      3'h1
`define TAT_FQ_1      3'h2
`define TAT_FQ_2      3'h4
`define TAT_FQ_3      3'h6
`define TAT_FQ_MAX    3'h6
// one-shot interrupt pulse timing
`define TAT_CLK_MHZ   200
`define TAT_PULSE_NS  100
`define TAT_PULSE_CYC ((`TAT_PULSE_NS * `TAT_CLK_MHZ) / 1000)
// bus responses
`define TAT_RESP_OK   2'h0
`define TAT_RESP_ERR  2'h2
`endif

// >>> rtl/tat_pkg.sv
package tat_pkg;
    // kind of a limit event
    typedef enum logic {KIND_HI, KIND_LO} tat_kind_e;
    // bus master to slave
    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } tat_axi_req_s;
    // slave to bus master
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } tat_axi_rsp_s;
    // converter result strobe
    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } tat_sample_s;
endpackage

// >>> rtl/tat_thermostat.sv
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "tat_consts.svh"
// Overview of operation
// - compare each stored sample against both limits
// - alarm active low, polarity bit makes high
// - mode bit picks comparator or interrupt
// - fault when at/above upper or at/below lower
// - queue field selects 1, 2, 4, 6
// - count faults, valid when queue reached
// - non-fault sample zeroes fault counter
// - comparator: set on upper, clear on lower
// - comparator ignores reads, writes, shutdown
// - interrupt-to-comparator keeps active alarm
// - general call clears alarm and config
// - interrupt: cleared by read, alert answer, shutdown
// - interrupt events alternate upper and lower
// - first interrupt event must be upper
// - comparator-to-interrupt keeps alarm until cleared
// - shutdown stops conversions, clear resumes
// - shutdown entry clears alarm in interrupt only
// - fault counter survives shutdown
// - shutdown exit asserts pending opposite event
// - trigger in shutdown runs one conversion
// - one-shot: comparator sets/clears, interrupt pulses
// - samples 16-bit signed, left aligned
module tat_thermostat (
    // clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // register bus
    input  wire tat_pkg::tat_axi_req_s axi_req,
    output tat_pkg::tat_axi_rsp_s      axi_rsp,
    // converter
    output logic                       conv_req,
    input  wire tat_pkg::tat_sample_s  conv_in,
    // serial engine events
    input  wire logic                  ara_answered,
    input  wire logic                  gcall_reset,
    // alarm pin
    output logic                       alert_pin
);
    import tat_pkg::*;

    localparam logic [4:0] PULSE_CYC = 5'(`TAT_PULSE_CYC);

    // software visible state
    logic [7:0]   cfg_reg;        // configuration bits
    logic [15:0]  low_reg;        // lower limit
    logic [15:0]  high_reg;       // upper limit
    logic [15:0]  temp_reg;       // last stored sample
    // bus slave state
    logic         aw_hold_reg;    // write address captured
    logic [7:0]   awaddr_reg;     // captured write address
    logic         w_hold_reg;     // write data captured
    logic [31:0]  wdata_reg;      // captured write data
    logic [3:0]   wstrb_reg;      // captured strobes
    logic         bvalid_reg;     // write answer pending
    logic [1:0]   bresp_reg;      // write answer code
    logic         rvalid_reg;     // read answer pending
    logic [31:0]  rdata_reg;      // read answer data
    logic [1:0]   rresp_reg;      // read answer code
    // thermostat state
    logic [2:0]   cnt_reg;        // consecutive fault count
    logic         vld_reg;        // a valid condition stands
    tat_kind_e    vld_kind_reg;   // kind of that condition
    logic         act_reg;        // alarm latched active
    tat_kind_e    expect_reg;     // next interrupt event kind
    logic [4:0]   pulse_reg;      // one-shot pulse cycles left
    logic         pd_prev_reg;    // shutdown bit last cycle
    logic         mode_prev_reg;  // mode bit last cycle
    logic         alert_reg;      // pin level

    // decoded controls
    logic         pd_on;          // shutdown selected
    logic         int_mode;       // interrupt mode selected
    logic         pd_enter;       // shutdown just entered
    logic         pd_exit;        // shutdown just left
    logic         mode_chg;       // mode bit flipped
    logic [2:0]   qlen;           // queue length
    // sample evaluation
    logic [15:0]  smp;            // masked sample
    logic         take;           // sample accepted
    logic         is_hi;          // at or above upper
    logic         is_lo;          // at or below lower
    tat_kind_e    kind;           // kind of this sample
    logic [2:0]   cnt_inc;        // count after this fault
    logic         valid_now;      // valid fault this cycle
    logic         oneshot;        // sample taken in shutdown
    logic         int_hit;        // interrupt event fires
    logic         exit_hit;       // pending event on exit
    // bus decode
    logic         wr_do;          // write performed
    logic         rd_do;          // read accepted
    logic         rd_hit;         // read of a mapped register
    logic         wr_cfg;         // write to configuration
    logic [31:0]  rdata_next;     // read mux
    logic         rd_map;         // read address mapped
    logic         wr_map;         // write address mapped

    // byte-lane merge into a 16-bit register
    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] data,
        input logic [3:0]  strb
    );
        logic [15:0] res;
        res = old;
        if (strb[0])
        begin
            res[7:0] = data[7:0];
        end
        if (strb[1])
        begin
            res[15:8] = data[15:8];
        end
        return res;
    endfunction

    // control decode
    assign pd_on    = cfg_reg[`TAT_CFG_PD];
    assign int_mode = cfg_reg[`TAT_CFG_MODE];
    assign pd_enter = pd_on & ~pd_prev_reg;
    assign pd_exit  = ~pd_on & pd_prev_reg;
    assign mode_chg = int_mode != mode_prev_reg;

    // queue length select
    always_comb
    begin
        case ({cfg_reg[`TAT_CFG_FQHI], cfg_reg[`TAT_CFG_FQLO]})
            2'h0:    qlen = `TAT_FQ_0;
            2'h1:    qlen = `TAT_FQ_1;
            2'h2:    qlen = `TAT_FQ_2;
            2'h3:    qlen = `TAT_FQ_3;
            default: qlen = `TAT_FQ_0;
        endcase
    end

    // converter runs free unless shut down; one-shot overrides
    assign conv_req = ~pd_on | cfg_reg[`TAT_CFG_TR];
    assign take     = conv_in.valid & conv_req;
    assign oneshot  = take & pd_on;
    assign smp      = conv_in.data & `TAT_TEMP_MASK;

    // limit compare, both signed; upper wins a tie of kinds
    assign is_hi = $signed(smp) >= $signed(high_reg);
    assign is_lo = $signed(smp) <= $signed(low_reg);
    assign kind  = is_hi ? KIND_HI : KIND_LO;

    // count saturates at the longest queue so it never wraps
    assign cnt_inc   = (cnt_reg >= `TAT_FQ_MAX) ? `TAT_FQ_MAX : cnt_reg + 3'h1;
    assign valid_now = take & (is_hi | is_lo) & (cnt_inc >= qlen);

    // interrupt events must match the expected kind
    assign int_hit  = valid_now & (kind == expect_reg);
    assign exit_hit = pd_exit & vld_reg & (vld_kind_reg == expect_reg);

    // stored sample
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            temp_reg <= `TAT_TEMP_RST;
        end
        else if (take)
        begin
            temp_reg <= smp;
        end
    end

    // fault counter; kept through shutdown and general call
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_reg <= 3'h0;
        end
        else if (take)
        begin
            if (is_hi | is_lo)
            begin
                cnt_reg <= cnt_inc;
            end
            else
            begin
                cnt_reg <= 3'h0;
            end
        end
    end

    // standing valid condition, looked at on shutdown exit
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            vld_reg      <= 1'b0;
            vld_kind_reg <= KIND_HI;
        end
        else if (take)
        begin
            vld_reg      <= valid_now;
            vld_kind_reg <= kind;
        end
    end

    // edge trackers for shutdown and mode
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pd_prev_reg   <= 1'b0;
            mode_prev_reg <= 1'b0;
        end
        else
        begin
            pd_prev_reg   <= pd_on;
            mode_prev_reg <= int_mode;
        end
    end

    // latched alarm
    always_ff @(posedge aclk)
    begin
        if (!aresetn || gcall_reset)
        begin
            act_reg <= 1'b0;
        end
        else if (!int_mode)
        begin
            // comparator: only valid conditions move it
            if (valid_now)
            begin
                act_reg <= (kind == KIND_HI);
            end
        end
        else if ((int_hit && !oneshot) || exit_hit)
        begin
            act_reg <= 1'b1;
        end
        else if (rd_hit || ara_answered || pd_enter)
        begin
            act_reg <= 1'b0;
        end
    end

    // expected interrupt event kind
    always_ff @(posedge aclk)
    begin
        if (!aresetn || gcall_reset || mode_chg)
        begin
            expect_reg <= KIND_HI;
        end
        else if (int_mode && (int_hit || exit_hit))
        begin
            expect_reg <= (expect_reg == KIND_HI) ? KIND_LO : KIND_HI;
        end
    end

    // one-shot interrupt pulse
    always_ff @(posedge aclk)
    begin
        if (!aresetn || gcall_reset)
        begin
            pulse_reg <= 5'h0;
        end
        else if (int_mode && int_hit && oneshot)
        begin
            pulse_reg <= PULSE_CYC;
        end
        else if (pulse_reg != 5'h0)
        begin
            pulse_reg <= pulse_reg - 5'h1;
        end
    end

    // pin level, registered; inactive high after reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            alert_reg <= 1'b1;
        end
        else if (cfg_reg[`TAT_CFG_INV])
        begin
            alert_reg <= act_reg | (pulse_reg != 5'h0);
        end
        else
        begin
            alert_reg <= ~(act_reg | (pulse_reg != 5'h0));
        end
    end
    assign alert_pin = alert_reg;

    // bus decode
    assign wr_do  = aw_hold_reg & w_hold_reg & ~bvalid_reg;
    assign wr_map = (awaddr_reg == `TAT_OFF_TEMP) | (awaddr_reg == `TAT_OFF_CFG)
                  | (awaddr_reg == `TAT_OFF_LOW) | (awaddr_reg == `TAT_OFF_HIGH)
                  | (awaddr_reg == `TAT_OFF_STAT);
    assign wr_cfg = wr_do & (awaddr_reg == `TAT_OFF_CFG);
    assign rd_do  = axi_req.arvalid & ~rvalid_reg;
    assign rd_hit = rd_do & rd_map;

    // configuration: general call restores defaults
    always_ff @(posedge aclk)
    begin
        if (!aresetn || gcall_reset)
        begin
            cfg_reg <= `TAT_CFG_RST;
        end
        else if (wr_cfg && wstrb_reg[0])
        begin
            cfg_reg <= wdata_reg[7:0];
            // trigger only takes hold while shut down
            cfg_reg[`TAT_CFG_TR] <= wdata_reg[`TAT_CFG_TR] & wdata_reg[`TAT_CFG_PD];
        end
        else if (oneshot)
        begin
            cfg_reg[`TAT_CFG_TR] <= 1'b0;
        end
    end

    // limit registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            low_reg  <= `TAT_LOW_RST;
            high_reg <= `TAT_HIGH_RST;
        end
        else if (wr_do && awaddr_reg == `TAT_OFF_LOW)
        begin
            low_reg <= merge16(low_reg, wdata_reg, wstrb_reg);
        end
        else if (wr_do && awaddr_reg == `TAT_OFF_HIGH)
        begin
            high_reg <= merge16(high_reg, wdata_reg, wstrb_reg);
        end
    end

    // write channels, taken in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_reg <= 1'b0;
            awaddr_reg  <= 8'h00;
            w_hold_reg  <= 1'b0;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
        end
        else
        begin
            if (axi_req.awvalid && axi_rsp.awready)
            begin
                aw_hold_reg <= 1'b1;
                awaddr_reg  <= {axi_req.awaddr[7:2], 2'h0};
            end
            else if (wr_do)
            begin
                aw_hold_reg <= 1'b0;
            end
            if (axi_req.wvalid && axi_rsp.wready)
            begin
                w_hold_reg <= 1'b1;
                wdata_reg  <= axi_req.wdata;
                wstrb_reg  <= axi_req.wstrb;
            end
            else if (wr_do)
            begin
                w_hold_reg <= 1'b0;
            end
        end
    end

    // write answer; unmapped gives an error
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= `TAT_RESP_OK;
        end
        else if (wr_do)
        begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_map ? `TAT_RESP_OK : `TAT_RESP_ERR;
        end
        else if (axi_req.bready)
        begin
            bvalid_reg <= 1'b0;
        end
    end

    // read mux; reserved bits read zero
    always_comb
    begin
        rd_map     = 1'b1;
        rdata_next = 32'h0000_0000;
        case ({axi_req.araddr[7:2], 2'h0})
            `TAT_OFF_TEMP: rdata_next[15:0] = temp_reg;
            `TAT_OFF_CFG:  rdata_next[7:0]  = cfg_reg;
            `TAT_OFF_LOW:  rdata_next[15:0] = low_reg;
            `TAT_OFF_HIGH: rdata_next[15:0] = high_reg;
            `TAT_OFF_STAT: rdata_next[7:0]  = {alert_reg, expect_reg, vld_kind_reg,
                                               vld_reg, cnt_reg, act_reg};
            default:       rd_map = 1'b0;
        endcase
    end

    // read answer, one cycle after the address is taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= `TAT_RESP_OK;
        end
        else if (rd_do)
        begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rdata_next;
            rresp_reg  <= rd_map ? `TAT_RESP_OK : `TAT_RESP_ERR;
        end
        else if (axi_req.rready)
        begin
            rvalid_reg <= 1'b0;
        end
    end

    // bus outputs; readies block while an answer waits
    always_comb
    begin
        axi_rsp.awready = ~aw_hold_reg & ~bvalid_reg;
        axi_rsp.wready  = ~w_hold_reg & ~bvalid_reg;
        axi_rsp.bvalid  = bvalid_reg;
        axi_rsp.bresp   = bresp_reg;
        axi_rsp.arready = ~rvalid_reg;
        axi_rsp.rvalid  = rvalid_reg;
        axi_rsp.rdata   = rdata_reg;
        axi_rsp.rresp   = rresp_reg;
    end
endmodule

// >>> verif/tat_host_model.sv
`timescale 1ns/1ps
module tat_host_model (
    // clock
    input  wire logic            aclk,
    // converter result and alert answer
    output tat_pkg::tat_sample_s conv_in,
    output logic                 ara_answered
);
    import tat_pkg::*;
    // idle at time zero
    initial
    begin
        conv_in      = '0;
        ara_answered = 1'b0;
    end
    // one result strobe; data scrambled after so stale data never looks valid
    task automatic convert(input logic [15:0] t);
        @(posedge aclk);
        conv_in <= '{valid: 1'b1, data: t};
        @(posedge aclk);
        conv_in <= '{valid: 1'b0, data: ~t};
    endtask
    // device answered an alert-response cycle
    task automatic answer();
        @(posedge aclk);
        ara_answered <= 1'b1;
        @(posedge aclk);
        ara_answered <= 1'b0;
    endtask
endmodule

// >>> verif/tat_thermostat_monitor.sv
`timescale 1ns/1ps
module tat_thermostat_monitor (
    // clock and reset
    input wire logic                  aclk,
    input wire logic                  aresetn,
    // register bus
    input wire tat_pkg::tat_axi_req_s axi_req,
    input wire tat_pkg::tat_axi_rsp_s axi_rsp,
    // converter
    input wire logic                  conv_req,
    input wire tat_pkg::tat_sample_s  conv_in,
    // serial engine events
    input wire logic                  ara_answered,
    input wire logic                  gcall_reset,
    // alarm pin
    input wire logic                  alert_pin
);
    import tat_pkg::*;
    logic [7:0]  quiet_reg; // cycles since last taken sample
    logic [7:0]  raddr_reg; // address of the read in flight
    logic [15:0] temp_reg;  // last taken sample, masked
    logic [15:0] rtemp_reg; // sample held when the read was taken
    logic        acc;       // sample taken this edge
    logic        rd_hit;    // read address taken this edge
    assign acc    = conv_in.valid & conv_req;
    assign rd_hit = axi_req.arvalid & axi_rsp.arready;
    // sample age, saturating so it never wraps into a false cause
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            quiet_reg <= 8'hFF;
        else if (acc)
            quiet_reg <= 8'h00;
        else if (quiet_reg != 8'hFF)
            quiet_reg <= quiet_reg + 8'h01;
    end
    // shadow of the stored sample and the read address
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            temp_reg  <= 16'h0000;
            rtemp_reg <= 16'h0000;
            raddr_reg <= 8'h00;
        end
        else
        begin
            if (acc)
                temp_reg <= conv_in.data & 16'hFFF0;
            // read data is taken at the address edge, before a new sample lands
            if (rd_hit)
            begin
                raddr_reg <= axi_req.araddr;
                rtemp_reg <= temp_reg;
            end
        end
    end
    // reset checks carry no disable: they watch the reset itself
    a_reset_pin_idle: assert property (@(posedge aclk) !aresetn |=> alert_pin)
        else $error("pin not inactive high after reset");
    a_reset_conv_on: assert property (@(posedge aclk) !aresetn |=> conv_req)
        else $error("converter not enabled after reset");
    a_gcall_pin_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        gcall_reset |=> ##1 alert_pin)
        else $error("general call left the pin active");
    a_gcall_conv_on: assert property (@(posedge aclk) disable iff (!aresetn)
        gcall_reset |=> conv_req)
        else $error("general call left shutdown set");
    // pin moves only after a sample, a bus access, an alert answer, a general call or reset
    a_pin_has_cause: assert property (@(posedge aclk) disable iff (!aresetn)
        $changed(alert_pin) |-> quiet_reg <= 8'd24 || $past(axi_rsp.bvalid)
            || $past(axi_rsp.bvalid, 2)
            || $past(ara_answered, 2) || $past(gcall_reset, 2) || $past(rd_hit, 2)
            || !$past(aresetn) || !$past(aresetn, 2))
        else $error("pin changed with no cause");
    a_conv_rise_cause: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(conv_req) |-> axi_rsp.bvalid || $past(gcall_reset) || !$past(aresetn))
        else $error("converter enabled with no write");
    a_conv_fall_cause: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(conv_req) |-> axi_rsp.bvalid || $past(acc))
        else $error("converter stopped with no write or one-shot");
    a_temp_read_value: assert property (@(posedge aclk) disable iff (!aresetn)
        axi_rsp.rvalid && raddr_reg == 8'h00 |-> axi_rsp.rdata == {16'h0000, rtemp_reg})
        else $error("temperature read differs from stored sample");
    c_gcall: cover property (@(posedge aclk) gcall_reset);
    c_ara: cover property (@(posedge aclk) ara_answered);
    c_oneshot: cover property (@(posedge aclk) $fell(conv_req));
    c_temp_read: cover property (@(posedge aclk) rd_hit && axi_req.araddr == 8'h00);
endmodule
bind tat_thermostat tat_thermostat_monitor i_mon (
    .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .conv_req(conv_req), .conv_in(conv_in), .ara_answered(ara_answered),
    .gcall_reset(gcall_reset), .alert_pin(alert_pin)
);

// >>> verif/tat_thermostat_tb.sv
`timescale 1ns/1ps
module tat_thermostat_tb;
    import tat_pkg::*;
    logic         aclk;       // 200 MHz clock
    logic         aresetn;    // sync reset
    tat_axi_req_s req;        // bus master side
    tat_axi_rsp_s rsp;        // slave answers
    logic         conv_req;   // converter may run
    tat_sample_s  conv_in;    // converter results
    logic         ara;        // alert answer pulse
    logic         gcall;      // general call pulse
    logic         alert_pin;  // alarm pin
    int           n_mismatch; // failed compares
    int           cmp_count;  // compares made
    int           cyc = 0;    // hang guard count
    logic [31:0]  d;          // last read data
    logic [1:0]   r;          // last read or write response
    int           len;        // queue length under test
    tat_thermostat i_dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
        .conv_req(conv_req), .conv_in(conv_in), .ara_answered(ara), .gcall_reset(gcall),
        .alert_pin(alert_pin));
    tat_host_model i_host (.aclk(aclk), .conv_in(conv_in), .ara_answered(ara));
    // free running clock
    initial
    begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    // hang guard: the run needs far fewer cycles than this
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_mismatch++;
            final_report();
        end
    end
    task automatic final_report();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // pin lags its latch by one edge, so let it settle
    task automatic pin(input logic exp);
        repeat (3) @(posedge aclk);
        #1;
        chk({31'h0, alert_pin}, {31'h0, exp});
    endtask
    // write: address and data offered together, each dropped when taken;
    // handshakes judged at the falling edge so the launch edge never races
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic aw_t;
        logic w_t;
        logic b_t;
        @(posedge aclk);
        req.awvalid <= 1'b1;
        req.awaddr  <= a;
        req.wvalid  <= 1'b1;
        req.wdata   <= v;
        req.wstrb   <= 4'hF;
        req.bready  <= 1'b1;
        forever
        begin
            @(negedge aclk);
            aw_t = req.awvalid && rsp.awready;
            w_t  = req.wvalid && rsp.wready;
            b_t  = rsp.bvalid && req.bready;
            r    = rsp.bresp;
            @(posedge aclk);
            if (aw_t)
                req.awvalid <= 1'b0;
            if (w_t)
                req.wvalid <= 1'b0;
            if (b_t)
            begin
                req.bready <= 1'b0;
                break;
            end
        end
    endtask
    // read into d and r
    task automatic rd(input logic [7:0] a);
        logic ar_t;
        logic r_t;
        @(posedge aclk);
        req.arvalid <= 1'b1;
        req.araddr  <= a;
        req.rready  <= 1'b1;
        forever
        begin
            @(negedge aclk);
            ar_t = req.arvalid && rsp.arready;
            r_t  = rsp.rvalid && req.rready;
            d    = rsp.rdata;
            r    = rsp.rresp;
            @(posedge aclk);
            if (ar_t)
                req.arvalid <= 1'b0;
            if (r_t)
            begin
                req.rready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(d, e);
    endtask
    task automatic cfg(input logic [31:0] v);
        wr(8'h04, v);
    endtask
    task automatic cv(input logic [15:0] t);
        i_host.convert(t);
    endtask
    // main sequence
    initial
    begin
        req        = '0;
        gcall      = 1'b0;
        aresetn    = 1'b0;
        n_mismatch = 0;
        cmp_count  = 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        // reset values, read-only write, a hole in the map
        rchk(8'h04, 32'h0);
        rchk(8'h08, 32'h4B00);
        wr(8'h0C, 32'h5000);
        wr(8'h00, 32'h1234);
        chk({30'h0, r}, 32'h0);
        rchk(8'h00, 32'h0);
        rd(8'h14);
        chk({30'h0, r}, 32'h2);
        pin(1'b1);
        // negative sample must compare signed, not as a huge value
        cv(16'hFF8F);
        pin(1'b1);
        rchk(8'h00, 32'hFF80);
        // comparator, queue of two: tie counts, a gap clears the count
        cfg(32'h08);
        cv(16'h4C00);
        cv(16'h5000);
        cv(16'h4C00);
        cv(16'h5000);
        pin(1'b1);
        cv(16'h5100);
        pin(1'b0);
        rd(8'h10);
        chk(d & 32'h0E, 32'h04);
        cfg(32'h09);
        pin(1'b0);
        chk({31'h0, conv_req}, 32'h0);
        cv(16'h3000);
        rchk(8'h00, 32'h5100);
        rd(8'h10);
        chk(d & 32'h0E, 32'h04);
        cfg(32'h08);
        cv(16'h4B00);
        cv(16'h4B00);
        pin(1'b1);
        cfg(32'h0C);
        pin(1'b0);
        // interrupt mode over every queue length
        for (int q = 0; q < 4; q++)
        begin
            len = (q == 0) ? 1 : 2 * q;
            cfg(32'h02 | (q << 3));
            cv(16'h4C00);
            repeat (len) cv(16'h4000);
            pin(1'b1);
            cv(16'h4C00);
            repeat (len - 1) cv(16'h5000);
            pin(1'b1);
            cv(16'h5000);
            pin(1'b0);
            rchk(8'h00, 32'h5000);
            pin(1'b1);
            repeat (len) cv(16'h4000);
            pin(1'b0);
            i_host.answer();
            pin(1'b1);
        end
        // shutdown drops an interrupt alarm; one-shot gives a short pulse
        cfg(32'h02);
        cv(16'h5000);
        pin(1'b0);
        cfg(32'h03);
        pin(1'b1);
        cfg(32'h83);
        cv(16'h4000);
        pin(1'b0);
        repeat (25) @(posedge aclk);
        pin(1'b1);
        chk({31'h0, conv_req}, 32'h0);
        cfg(32'h02);
        pin(1'b1);
        // mode switches keep an active alarm
        cfg(32'h00);
        cv(16'h5000);
        cfg(32'h02);
        pin(1'b0);
        rd(8'h04);
        pin(1'b1);
        cfg(32'h00);
        cfg(32'h02);
        cv(16'h5000);
        cfg(32'h00);
        pin(1'b0);
        rd(8'h04);
        pin(1'b0);
        cv(16'h4000);
        pin(1'b1);
        // general call clears pin and config
        cfg(32'h10);
        cv(16'h5000);
        pin(1'b0);
        @(posedge aclk);
        gcall <= 1'b1;
        @(posedge aclk);
        gcall <= 1'b0;
        pin(1'b1);
        rchk(8'h04, 32'h0);
        final_report();
    end
endmodule
